// ---- hdl/charge_time_pkg.sv ----
// Constants for the charge and time edge control block
// Assumes a classic Wishbone slave with 8-bit registers in 32-bit words
`default_nettype none
package charge_time_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_CTRL_HIGH = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CTRL_LOW = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CURRENT = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_IRQ_FLAG = 4'hc;
    // Control high fields
    localparam int HI_UNIT_ENABLE = 7;
    localparam int HI_IDLE_STOP = 5;
    localparam int HI_DELAY_MODE = 4;
    localparam int HI_EDGE_UNBLOCK = 3;
    localparam int HI_ORDER_ENABLE = 2;
    localparam int HI_DISCHARGE = 1;
    localparam int HI_CONV_TRIG = 0;
    localparam logic [7:0] HI_WRITE_MASK = 8'hbf;
    // Control low fields
    localparam int LO_TWO_POL = 7;
    localparam int LO_TWO_SEL = 5;
    localparam int LO_ONE_POL = 4;
    localparam int LO_ONE_SEL = 2;
    localparam int LO_TWO_SEEN = 1;
    localparam int LO_ONE_SEEN = 0;
    // Current control fields
    localparam int CUR_TRIM = 2;
    localparam int CUR_RANGE = 0;
    // Interrupt flag and enable bit position
    localparam int IRQ_BIT = 3;
    // Source select codes
    localparam logic [1:0] SRC_PIN_ONE = 2'h3;
    localparam logic [1:0] SRC_PIN_TWO = 2'h2;
    localparam logic [1:0] SRC_EVT_ONE = 2'h1;
    localparam logic [1:0] SRC_EVT_TWO = 2'h0;
    // Reset values
    localparam logic [7:0] RST_CTRL_HIGH = 8'h00;
    localparam logic [7:0] RST_CTRL_LOW = 8'h00;
    localparam logic [7:0] RST_CURRENT = 8'h00;
endpackage
`default_nettype wire

// ---- hdl/level_sync.sv ----
// Two-flop synchroniser for a group of asynchronous levels
// Assumes one clock and synchronous active-low reset
`default_nettype none
module level_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_t;
    sync_state_t s_q;
    sync_state_t s_d;
    always_comb begin
        s_d.meta = i_async;
        s_d.sync = s_q.meta;
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign o_sync = s_q.sync;
endmodule
`default_nettype wire

// ---- hdl/charge_time_unit.sv ----
// Edge control, status and current source gating of the charge time unit
// Assumes classic Wishbone slave; edge pins asynchronous, events on this clock
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`default_nettype none
module charge_time_unit
    import charge_time_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [charge_time_pkg::ADDR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Edge sources
    input wire logic i_edge_pin_one,
    input wire logic i_edge_pin_two,
    input wire logic i_compare_unit_event_one,
    input wire logic i_compare_unit_event_two,
    // Interrupt enable from the system enable register
    input wire logic i_irq_enable,
    // Analog controls
    output logic o_source_on,
    output logic o_discharge,
    output logic [1:0] o_current_range_sel,
    output logic [5:0] o_current_trim,
    output logic o_delay_mode_select,
    output logic o_unit_enable,
    // Converter trigger and interrupt
    output logic o_conv_start,
    output logic o_irq
);
    import charge_time_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl_high;
        logic [7:0] ctrl_low;
        logic [7:0] current;
        logic flag;
        logic ack;
        logic [31:0] rdata;
        logic on;
        logic discharge;
        logic conv;
        logic irq;
    } unit_state_t;

    unit_state_t s_q;
    unit_state_t s_d;
    logic [1:0] pins_sync;
    logic [1:0] active;
    logic [1:0] hw_set;
    logic [7:0] low_wr;
    logic access;
    logic wr_low;
    logic next_one;
    logic next_two;

    level_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_edge_pin_two, i_edge_pin_one}),
        .o_sync(pins_sync)
    );

    // Source select per channel
    function automatic logic pick(input logic [1:0] sel);
        unique case (sel)
            SRC_PIN_ONE: pick = pins_sync[0];
            SRC_PIN_TWO: pick = pins_sync[1];
            SRC_EVT_ONE: pick = i_compare_unit_event_one;
            SRC_EVT_TWO: pick = i_compare_unit_event_two;
        endcase
    endfunction

    always_comb begin
        access = i_wb_cyc && i_wb_stb && !s_q.ack;
        // Level compare after polarity
        active[0] = pick(s_q.ctrl_low[LO_ONE_SEL+:2]) == s_q.ctrl_low[LO_ONE_POL];
        active[1] = pick(s_q.ctrl_low[LO_TWO_SEL+:2]) == s_q.ctrl_low[LO_TWO_POL];
        hw_set = '0;
        if (s_q.ctrl_high[HI_UNIT_ENABLE] && s_q.ctrl_high[HI_EDGE_UNBLOCK]) begin
            hw_set[0] = active[0];
            hw_set[1] = active[1] && (!s_q.ctrl_high[HI_ORDER_ENABLE]
                || s_q.ctrl_low[LO_ONE_SEEN]);
        end
        wr_low = access && i_wb_we && i_wb_sel[0] && i_wb_adr == OFS_CTRL_LOW;
        low_wr = wr_low ? i_wb_dat[7:0] : s_q.ctrl_low;
        s_d = s_q;
        // Software write wins on the seen bits, hardware sets otherwise
        next_one = wr_low ? low_wr[LO_ONE_SEEN] : (s_q.ctrl_low[LO_ONE_SEEN] | hw_set[0]);
        next_two = wr_low ? low_wr[LO_TWO_SEEN] : (s_q.ctrl_low[LO_TWO_SEEN] | hw_set[1]);
        s_d.ctrl_low = {low_wr[7:2], next_two, next_one};
        s_d.ack = access;
        s_d.rdata = '0;
        if (access && i_wb_we && i_wb_sel[0]) begin
            unique case (i_wb_adr)
                OFS_CTRL_HIGH: s_d.ctrl_high = i_wb_dat[7:0] & HI_WRITE_MASK;
                OFS_CURRENT: s_d.current = i_wb_dat[7:0];
                default: ;
            endcase
        end
        if (access && !i_wb_we) begin
            unique case (i_wb_adr)
                OFS_CTRL_HIGH: s_d.rdata = {24'h0, s_q.ctrl_high};
                OFS_CTRL_LOW: s_d.rdata = {24'h0, s_q.ctrl_low};
                OFS_CURRENT: s_d.rdata = {24'h0, s_q.current};
                OFS_IRQ_FLAG: s_d.rdata = {28'h0, s_q.flag, 3'h0};
                default: s_d.rdata = '0;
            endcase
        end
        s_d.on = s_q.ctrl_low[LO_ONE_SEEN] ^ s_q.ctrl_low[LO_TWO_SEEN];
        s_d.discharge = s_q.ctrl_high[HI_DISCHARGE];
        // Conversion pulse when the second edge completes the interval
        s_d.conv = s_q.ctrl_high[HI_CONV_TRIG] && s_q.on && !s_d.on;
        // Flag clears by writing zero to bit 3; a new event wins
        if (access && i_wb_we && i_wb_sel[0] && i_wb_adr == OFS_IRQ_FLAG
            && !i_wb_dat[IRQ_BIT]) begin
            s_d.flag = 1'b0;
        end
        if (s_q.on && !s_d.on) begin
            s_d.flag = 1'b1;
        end
        s_d.irq = s_q.flag && i_irq_enable;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
            s_q.ctrl_high <= RST_CTRL_HIGH;
            s_q.ctrl_low <= RST_CTRL_LOW;
            s_q.current <= RST_CURRENT;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_wb_dat = s_q.rdata;
    assign o_wb_ack = s_q.ack;
    assign o_source_on = s_q.on;
    assign o_discharge = s_q.discharge;
    assign o_current_range_sel = s_q.current[CUR_RANGE+:2];
    assign o_current_trim = s_q.current[CUR_TRIM+:6];
    assign o_delay_mode_select = s_q.ctrl_high[HI_DELAY_MODE];
    assign o_unit_enable = s_q.ctrl_high[HI_UNIT_ENABLE];
    assign o_conv_start = s_q.conv;
    assign o_irq = s_q.irq;

    property p_source_xor;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        1 |=> o_source_on == ($past(s_q.ctrl_low[0]) ^ $past(s_q.ctrl_low[1]));
    endproperty
    a_source_xor: assert property (p_source_xor) else $error("source gate wrong");

    property p_flag_on_off;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(o_source_on) |-> s_q.flag;
    endproperty
    a_flag_on_off: assert property (p_flag_on_off) else $error("flag not set");

    property p_irq_gate;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_irq |-> $past(s_q.flag) && $past(i_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without cause");

    property p_blocked;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !s_q.ctrl_high[HI_EDGE_UNBLOCK] && !wr_low |=> $stable(s_q.ctrl_low[1:0]);
    endproperty
    a_blocked: assert property (p_blocked) else $error("edge while blocked");

    property p_order;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        s_q.ctrl_high[HI_ORDER_ENABLE] && !s_q.ctrl_low[0] && !s_q.ctrl_low[1] && !wr_low
        |=> !s_q.ctrl_low[1];
    endproperty
    a_order: assert property (p_order) else $error("edge two out of order");

    property p_level_set;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        hw_set[0] && !wr_low |=> s_q.ctrl_low[0];
    endproperty
    a_level_set: assert property (p_level_set) else $error("edge one missed");

    property p_conv;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_conv_start |-> $past(s_q.ctrl_high[HI_CONV_TRIG]) && $fell(o_source_on);
    endproperty
    a_conv: assert property (p_conv) else $error("bad conversion pulse");

    property p_sw_write;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        wr_low |=> s_q.ctrl_low[1:0] == $past(i_wb_dat[1:0]);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("status write lost");

    property p_ack_pulse;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_wb_ack |=> !o_wb_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");

    property p_range_write;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        access && i_wb_we && i_wb_sel[0] && i_wb_adr == OFS_CURRENT
        |=> o_current_range_sel == $past(i_wb_dat[CUR_RANGE+:2]);
    endproperty
    a_range_write: assert property (p_range_write) else $error("range not taken");

    property p_trim_write;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        access && i_wb_we && i_wb_sel[0] && i_wb_adr == OFS_CURRENT
        |=> o_current_trim == $past(i_wb_dat[CUR_TRIM+:6]);
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("trim not taken");

    property p_current_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !(access && i_wb_we && i_wb_sel[0] && i_wb_adr == OFS_CURRENT)
        |=> $stable(o_current_trim) && $stable(o_current_range_sel);
    endproperty
    a_current_hold: assert property (p_current_hold) else $error("current field moved");

    property p_one_pin;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        s_q.ctrl_low[LO_ONE_SEL+:2] == SRC_PIN_ONE
        |-> active[0] == (pins_sync[0] == s_q.ctrl_low[LO_ONE_POL]);
    endproperty
    a_one_pin: assert property (p_one_pin) else $error("edge one pin wrong");

    property p_two_pin;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        s_q.ctrl_low[LO_TWO_SEL+:2] == SRC_PIN_TWO
        |-> active[1] == (pins_sync[1] == s_q.ctrl_low[LO_TWO_POL]);
    endproperty
    a_two_pin: assert property (p_two_pin) else $error("edge two pin wrong");

    property p_one_event;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        s_q.ctrl_low[LO_ONE_SEL+:2] == SRC_EVT_ONE
        |-> active[0] == (i_compare_unit_event_one == s_q.ctrl_low[LO_ONE_POL]);
    endproperty
    a_one_event: assert property (p_one_event) else $error("edge one event wrong");

    property p_two_event;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        s_q.ctrl_low[LO_TWO_SEL+:2] == SRC_EVT_TWO
        |-> active[1] == (i_compare_unit_event_two == s_q.ctrl_low[LO_TWO_POL]);
    endproperty
    a_two_event: assert property (p_two_event) else $error("edge two event wrong");

    property p_two_set;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        hw_set[1] && !wr_low |=> s_q.ctrl_low[LO_TWO_SEEN];
    endproperty
    a_two_set: assert property (p_two_set) else $error("edge two missed");

    property p_disabled;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !s_q.ctrl_high[HI_UNIT_ENABLE] && !wr_low |=> $stable(s_q.ctrl_low[1:0]);
    endproperty
    a_disabled: assert property (p_disabled) else $error("edge while disabled");

    property p_reconfig;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        wr_low ##1 (active[0] && s_q.ctrl_high[HI_UNIT_ENABLE]
            && s_q.ctrl_high[HI_EDGE_UNBLOCK] && !wr_low)
        |=> s_q.ctrl_low[LO_ONE_SEEN];
    endproperty
    a_reconfig: assert property (p_reconfig) else $error("match after write missed");

    property p_reset_state;
        @(posedge i_ref_clk)
        !i_rst_n |=> s_q.ctrl_high == RST_CTRL_HIGH && s_q.ctrl_low == RST_CTRL_LOW;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    property p_discharge_out;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        1 |=> o_discharge == $past(s_q.ctrl_high[HI_DISCHARGE]);
    endproperty
    a_discharge_out: assert property (p_discharge_out) else $error("discharge wrong");

    property p_mode_write;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        access && i_wb_we && i_wb_sel[0] && i_wb_adr == OFS_CTRL_HIGH
        |=> o_delay_mode_select == $past(i_wb_dat[HI_DELAY_MODE]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode not taken");

    property p_irq_off;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !$past(i_irq_enable) |-> !o_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

    property p_flag_clear;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        access && i_wb_we && i_wb_sel[0] && i_wb_adr == OFS_IRQ_FLAG && !i_wb_dat[IRQ_BIT]
            && !(s_q.on && !s_d.on) |=> !s_q.flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_conv_gate;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !s_q.ctrl_high[HI_CONV_TRIG] |=> !o_conv_start;
    endproperty
    a_conv_gate: assert property (p_conv_gate) else $error("conversion while off");

    property p_sel_ignored;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        access && i_wb_we && !i_wb_sel[0]
        |=> $stable(s_q.current) && $stable(s_q.ctrl_high);
    endproperty
    a_sel_ignored: assert property (p_sel_ignored) else $error("lane off write taken");

    c_source_on: cover property (@(posedge i_ref_clk) $rose(o_source_on));
    c_irq: cover property (@(posedge i_ref_clk) $rose(o_irq));
    c_conv: cover property (@(posedge i_ref_clk) o_conv_start);
    c_order_hold: cover property (@(posedge i_ref_clk)
        s_q.ctrl_high[HI_ORDER_ENABLE] && active[1] && !s_q.ctrl_low[LO_ONE_SEEN]);
    c_reconfig: cover property (@(posedge i_ref_clk) wr_low ##1 hw_set[0]);
endmodule
`default_nettype wire

// ---- sim/edge_adc_model.sv ----
// Far side model: edge pins, compare unit events and converter
// Assumes the bench sets levels through set_levels and reads conv_count
`default_nettype none
module edge_adc_model (
    // Clock
    input wire logic i_ref_clk,
    // Converter trigger
    input wire logic i_conv_start,
    // Edge sources
    output logic o_pin_one,
    output logic o_pin_two,
    output logic o_evt_one,
    output logic o_evt_two
);
    timeunit 1ns;
    timeprecision 1ns;
    int conv_count = 0;
    initial {o_pin_one, o_pin_two, o_evt_one, o_evt_two} = 4'h0;
    // Converter counts one start per trigger pulse
    always @(posedge i_ref_clk) if (i_conv_start) conv_count <= conv_count + 1;
    // Levels change just after an edge
    task automatic set_levels(input logic [3:0] lv);
        @(posedge i_ref_clk);
        {o_pin_one, o_pin_two, o_evt_one, o_evt_two} <= lv;
    endtask
endmodule
`default_nettype wire

// ---- sim/tb_charge_time_unit.sv ----
// Testbench for the charge time unit edge control
// Assumes a one-cycle Wishbone answer and the far side model beside it
`default_nettype none
module tb_charge_time_unit;
    timeunit 1ns;
    timeprecision 1ns;
    import charge_time_pkg::*;
    logic clk, rst_n, cyc, stb, we, irq_en;
    logic [ADDR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q_ign;
    logic ack, pin1, pin2, ev1, ev2, src_on, dis, dmode, uen, conv, irq;
    logic [1:0] rng;
    logic [5:0] trim;
    int fail_count = 0, check_count = 0, cycles = 0;
    charge_time_unit u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_edge_pin_one(pin1), .i_edge_pin_two(pin2),
        .i_compare_unit_event_one(ev1), .i_compare_unit_event_two(ev2),
        .i_irq_enable(irq_en), .o_source_on(src_on), .o_discharge(dis),
        .o_current_range_sel(rng), .o_current_trim(trim), .o_delay_mode_select(dmode),
        .o_unit_enable(uen), .o_conv_start(conv), .o_irq(irq));
    edge_adc_model u_far (.i_ref_clk(clk), .i_conv_start(conv), .o_pin_one(pin1),
        .o_pin_two(pin2), .o_evt_one(ev1), .o_evt_two(ev2));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic stop_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Classic single cycle; holds until ack is sampled high
    task automatic bus(input logic w, input logic [3:0] s, input logic [ADDR_W-1:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, s, a, 24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        {cyc, stb, we} <= 3'h0;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, 4'h1, a, d, q);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, 4'h1, a, 8'h00, q);
        check($sformatf("reg %h", a), {24'h0, exp}, q);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        {rst_n, cyc, stb, we, irq_en} <= 5'h0;
        sel <= 4'h0;
        adr <= '0;
        wdat <= '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL_HIGH, 8'h00);
        rd(OFS_CTRL_LOW, 8'h00);
        rd(OFS_CURRENT, 8'h00);
        rd(4'h1, 8'h00);
        wr(OFS_CURRENT, 8'h81);
        rd(OFS_CURRENT, 8'h81);
        // Write with byte lane off is ignored
        bus(1'b1, 4'h0, OFS_CURRENT, 8'h55, q_ign);
        rd(OFS_CURRENT, 8'h81);
        tick(3);
        check("range", 2'h1, rng);
        check("trim", 6'h20, trim);
        // Software gating of the source
        irq_en <= 1'b1;
        wr(OFS_CTRL_LOW, 8'h01);
        tick(3);
        check("source", 1'b1, src_on);
        wr(OFS_CTRL_LOW, 8'h03);
        tick(3);
        check("source", 1'b0, src_on);
        rd(OFS_IRQ_FLAG, 8'h08);
        check("irq", 1'b1, irq);
        irq_en <= 1'b0;
        tick(3);
        check("irq", 1'b0, irq);
        wr(OFS_IRQ_FLAG, 8'h00);
        rd(OFS_IRQ_FLAG, 8'h00);
        // Pins positive, blocked edges
        wr(OFS_CTRL_HIGH, 8'h00);
        wr(OFS_CTRL_LOW, 8'hdc);
        wr(OFS_CTRL_HIGH, 8'h81);
        u_far.set_levels(4'hc);
        tick(6);
        rd(OFS_CTRL_LOW, 8'hdc);
        wr(OFS_CTRL_HIGH, 8'h09);
        tick(6);
        rd(OFS_CTRL_LOW, 8'hdc);
        u_far.set_levels(4'h0);
        wr(OFS_CTRL_HIGH, 8'h89);
        u_far.set_levels(4'h8);
        tick(6);
        rd(OFS_CTRL_LOW, 8'hdd);
        check("source", 1'b1, src_on);
        u_far.set_levels(4'hc);
        tick(6);
        rd(OFS_CTRL_LOW, 8'hdf);
        check("conv", 1, u_far.conv_count);
        // Level match on reconfigure, negative polarity on edge two
        wr(OFS_CTRL_LOW, 8'h5c);
        tick(3);
        rd(OFS_CTRL_LOW, 8'h5d);
        u_far.set_levels(4'h8);
        tick(6);
        rd(OFS_CTRL_LOW, 8'h5f);
        // Ordered edges
        u_far.set_levels(4'h0);
        wr(OFS_CTRL_LOW, 8'hdc);
        wr(OFS_CTRL_HIGH, 8'h8c);
        u_far.set_levels(4'h4);
        tick(6);
        rd(OFS_CTRL_LOW, 8'hdc);
        u_far.set_levels(4'hc);
        tick(6);
        rd(OFS_CTRL_LOW, 8'hdf);
        // Event sources 01 and 00
        u_far.set_levels(4'h0);
        wr(OFS_CTRL_HIGH, 8'h88);
        wr(OFS_CTRL_LOW, 8'h94);
        u_far.set_levels(4'h2);
        tick(4);
        rd(OFS_CTRL_LOW, 8'h95);
        u_far.set_levels(4'h3);
        tick(4);
        rd(OFS_CTRL_LOW, 8'h97);
        // Discharge and delay mode
        wr(OFS_CTRL_HIGH, 8'hda);
        rd(OFS_CTRL_HIGH, 8'h9a);
        tick(3);
        check("discharge", 1'b1, dis);
        check("mode", 1'b1, dmode);
        check("enable", 1'b1, uen);
        // Reset in mid-run returns defaults
        rst_n <= 1'b0;
        tick(4);
        rst_n <= 1'b1;
        rd(OFS_CTRL_HIGH, 8'h00);
        rd(OFS_CTRL_LOW, 8'h00);
        check("discharge", 1'b0, dis);
        check("mode", 1'b0, dmode);
        stop_test();
    end
endmodule
`default_nettype wire
